// ---- sim/cppm_enc_model.sv ----
// encoder and measured-signal source facing the counter block's pins
`timescale 1ns/1ps
`default_nettype none
module cppm_enc_model (
  input wire logic mclk,
  output logic src_in,
  output logic start_in,
  output logic stop_in,
  output logic enc_a,
  output logic enc_b,
  output logic enc_z
);
  localparam logic [7:0] SEQ = {2'b00, 2'b10, 2'b11, 2'b01};
  logic [1:0] ph;
  // all pins idle low
  initial begin
    {src_in, start_in, stop_in, enc_a, enc_b, enc_z} = 6'h00;
    ph = 2'h0;
  end
  // one pin change after an edge, held 4 cycles so the sync chain sees it
  task automatic drive(input int p, input logic v);
    @(posedge mclk);
    case (p)
      0: src_in <= v;
      1: start_in <= v;
      2: stop_in <= v;
      3: enc_a <= v;
      4: enc_b <= v;
      default: enc_z <= v;
    endcase
    repeat (3) @(posedge mclk);
  endtask
  // n high-low pulses: 0 source, 1 start, 2 stop, 3 A, 4 B
  task automatic pulse(input int p, input int n);
    repeat (n) begin
      drive(p, 1'b1);
      drive(p, 1'b0);
    end
  endtask
  // n quadrature cycles, one channel at a time; fwd means A leads B
  task automatic quad(input bit fwd, input int n);
    logic [1:0] nx;
    repeat (4 * n) begin
      ph = fwd ? ph + 2'h1 : ph - 2'h1;
      nx = SEQ[6 - 2 * ph +: 2];
      if (nx[1] !== enc_a) begin
        drive(3, nx[1]);
      end else begin
        drive(4, nx[0]);
      end
    end
  endtask
endmodule // cppm_enc_model
`default_nettype wire

// ---- sim/cppm_top_props.sv ----
// bus-side assertions for the counter block, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module cppm_top_props import cppm_pkg::*; (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cppm_pkg::ADDR_W-1:0] paddr,
  input wire logic [cppm_pkg::CNT_W-1:0] pwdata,
  input wire logic [cppm_pkg::CNT_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
  logic [CNT_W-1:0] rel_reg, rel_next;
  logic map, setup, rd_set, wr_acc;
  // address decode and bus phases
  assign map = paddr inside {REG_CTRL, REG_RELOAD, REG_CMD, REG_COUNT, REG_DATA, REG_STATUS};
  assign setup = psel && !penable;
  assign rd_set = setup && !pwrite;
  assign wr_acc = psel && penable && pwrite;
  // shadow of the configuration, so readback ties to the write that made it
  always_comb begin
    ctrl_next = ctrl_reg;
    rel_next = rel_reg;
    if (wr_acc && paddr == REG_CTRL) begin
      ctrl_next = pwdata[CTRL_W-1:0];
    end
    if (wr_acc && paddr == REG_RELOAD) begin
      rel_next = pwdata;
    end
  end
  // registers of the shadow
  always_ff @(posedge mclk) begin
    ctrl_reg <= sys_rst ? CTRL_RST : ctrl_next;
    rel_reg <= sys_rst ? CNT_ZERO : rel_next;
  end
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  property p_rdy_on; (psel && penable) |-> pready; endproperty
  a_rdy_on: assert property (p_rdy_on) else $error("no ready in access");
  property p_rdy_off; !(psel && penable) |-> !pready; endproperty
  a_rdy_off: assert property (p_rdy_off) else $error("ready outside access");
  property p_err_set; (setup && !map) |=> pslverr; endproperty
  a_err_set: assert property (p_err_set) else $error("no error on bad address");
  property p_err_clr; (setup && map) |=> !pslverr; endproperty
  a_err_clr: assert property (p_err_clr) else $error("error on good address");
  property p_err_hold; !setup |=> $stable(pslverr); endproperty
  a_err_hold: assert property (p_err_hold) else $error("error flag moved");
  property p_rd_hold; !setup |=> $stable(prdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_rd_bad; (rd_set && !map) |=> prdata == CNT_ZERO; endproperty
  a_rd_bad: assert property (p_rd_bad) else $error("bad address read not zero");
  property p_ctrl; (rd_set && paddr == REG_CTRL) |=> prdata == {21'h0, ctrl_reg}; endproperty
  a_ctrl: assert property (p_ctrl) else $error("control readback wrong");
  property p_rel; (rd_set && paddr == REG_RELOAD) |=> prdata == rel_reg; endproperty
  a_rel: assert property (p_rel) else $error("reload readback wrong");
  property p_rst; $fell(sys_rst) |-> (prdata == CNT_ZERO) && !pslverr; endproperty
  a_rst: assert property (p_rst) else $error("bus outputs not cleared");
endmodule // cppm_top_props
bind cppm_top cppm_top_props u_props (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr));
`default_nettype wire

// ---- sim/cppm_top_tb.sv ----
// self-checking bench of the counter position / period measure block
`timescale 1ns/1ps
`default_nettype none
module cppm_top_tb;
  import cppm_pkg::*;
  logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
  logic [ADDR_W-1:0] paddr;
  logic [CNT_W-1:0] pwdata, prdata, r;
  logic src_in, start_in, stop_in, enc_a, enc_b, enc_z;
  int n_fail, n_tests;
  cppm_top dut (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_in(src_in), .start_in(start_in), .stop_in(stop_in),
    .enc_a(enc_a), .enc_b(enc_b), .enc_z(enc_z));
  cppm_enc_model u_enc (.mclk(mclk), .src_in(src_in), .start_in(start_in),
    .stop_in(stop_in), .enc_a(enc_a), .enc_b(enc_b), .enc_z(enc_z));
  // 200 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [CNT_W-1:0] got, input logic [CNT_W-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one bus transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [CNT_W-1:0] d);
    int k;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      $display("[ERR] %0t bus never answered", $time);
      complete_run();
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [CNT_W-1:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [CNT_W-1:0] e);
    apb(1'b0, a, CNT_ZERO);
    chk(r, e);
  endtask
  // disarm, set the mode, arm (arm clears the counter)
  task automatic cfg(input logic [CNT_W-1:0] c);
    wr(REG_CMD, 32'h0000_0002);
    wr(REG_CTRL, c);
    wr(REG_CMD, 32'h0000_0001);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    rd(REG_CTRL, CNT_ZERO);
    rd(REG_RELOAD, CNT_ZERO);
    wr(REG_CTRL, 32'hFFFF_F5B6);
    rd(REG_CTRL, 32'h0000_05B6);
    wr(REG_RELOAD, 32'hA5C3_0F96);
    rd(REG_RELOAD, 32'hA5C3_0F96);
    rd(8'h18, CNT_ZERO);
    chk({31'h0, err}, CNT_ONE);
  endtask
  task automatic t_period();
    cfg(32'h0000_0000);
    u_enc.pulse(0, 2);
    u_enc.pulse(2, 1);
    u_enc.pulse(0, 5);
    u_enc.pulse(2, 1);
    rd(REG_STATUS, 32'h0000_0004);
    rd(REG_DATA, 32'h0000_0005);
  endtask
  // up three cycles, down one, for each quadrature decode
  task automatic t_quad();
    for (int d = 0; d < 3; d++) begin
      cfg(32'h0000_0001 | (d << 2));
      rd(REG_STATUS, 32'h0000_0003);
      u_enc.quad(1'b1, 3);
      u_enc.quad(1'b0, 1);
      rd(REG_COUNT, 32'(2 << d));
      wr(REG_CMD, 32'h0000_0002);
      u_enc.quad(1'b1, 1);
      rd(REG_COUNT, 32'(2 << d));
    end
  endtask
  task automatic t_two_pulse();
    cfg(32'h0000_000D);
    wr(REG_COUNT, 32'h0000_0055);
    u_enc.pulse(3, 4);
    u_enc.pulse(4, 1);
    rd(REG_COUNT, 32'h0000_0003);
  endtask
  // index reload in phase A=0 B=0, quad decode
  task automatic t_reload();
    wr(REG_RELOAD, 32'h0000_0064);
    cfg(32'h0000_0209);
    u_enc.drive(5, 1'b1);
    rd(REG_COUNT, 32'h0000_0064);
    u_enc.quad(1'b1, 1);
    rd(REG_COUNT, 32'h0000_0064);
    u_enc.drive(5, 1'b0);
    u_enc.quad(1'b1, 1);
    rd(REG_COUNT, 32'h0000_0068);
  endtask
  // falling sample edges, reader stalls until the queue overflows
  task automatic t_sample();
    cfg(32'h0000_0501);
    for (int i = 0; i < 4; i++) begin
      u_enc.drive(2, 1'b1);
      u_enc.quad(1'b1, 1);
      u_enc.drive(2, 1'b0);
    end
    apb(1'b0, REG_STATUS, CNT_ZERO);
    chk({30'h0, r[3:2]}, 32'h0000_0003);
    for (int i = 1; i < 4; i++) begin
      rd(REG_DATA, 32'(i));
    end
    rd(REG_DATA, CNT_ZERO);
    wr(REG_STATUS, 32'h0000_0008);
    apb(1'b0, REG_STATUS, CNT_ZERO);
    chk({30'h0, r[3:2]}, CNT_ZERO);
  endtask
  // start on falling edge, stop on rising edge
  task automatic t_sep();
    cfg(32'h0000_0082);
    u_enc.pulse(0, 2);
    u_enc.drive(1, 1'b1);
    u_enc.pulse(0, 1);
    u_enc.drive(1, 1'b0);
    u_enc.pulse(0, 3);
    u_enc.pulse(1, 1);
    u_enc.pulse(0, 2);
    u_enc.drive(2, 1'b1);
    u_enc.pulse(0, 2);
    u_enc.drive(2, 1'b0);
    rd(REG_DATA, 32'h0000_0005);
  endtask
  // main sequence
  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    n_fail = 0;
    n_tests = 0;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge mclk);
    t_regs();
    t_period();
    t_quad();
    t_two_pulse();
    t_reload();
    t_sample();
    t_sep();
    complete_run();
  end
endmodule // cppm_top_tb
`default_nettype wire

// ---- src/cppm_buf2.sv ----
// two-entry word buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module cppm_buf2 (
  input wire logic mclk,
  input wire logic sys_rst,
  cppm_stream_if.snk fill,
  cppm_stream_if.src drain
);
  import cppm_pkg::*;

  logic [CNT_W-1:0] mem_reg [BUF_DEPTH];
  logic wr_reg;
  logic wr_next;
  logic rd_reg;
  logic rd_next;
  logic [1:0] used_reg;
  logic [1:0] used_next;
  logic push;
  logic pop;

  // honest full and empty from the fill level
  assign fill.ready = (used_reg != 2'h2);
  assign drain.valid = (used_reg != 2'h0);
  assign drain.data = mem_reg[rd_reg];
  assign push = fill.valid & fill.ready;
  assign pop = drain.valid & drain.ready;

  // pointer and level update
  always_comb begin
    wr_next = push ? ~wr_reg : wr_reg;
    rd_next = pop ? ~rd_reg : rd_reg;
    used_next = used_reg;
    if (push && !pop) begin
      used_next = used_reg + 2'h1;
    end else if (pop && !push) begin
      used_next = used_reg - 2'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      used_reg <= 2'h0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      used_reg <= used_next;
    end
  end

  // storage needs no reset; it is read only when marked used
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_reg[wr_reg] <= fill.data;
    end
  end
endmodule // cppm_buf2
`default_nettype wire

// ---- src/cppm_pkg.sv ----
// shared constants and types of the counter position / period measure block
package cppm_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int CNT_W = 32;
  localparam int ADDR_W = 8;
  localparam int CTRL_W = 11;
  localparam int BUF_DEPTH = 2;
  localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_RELOAD = 8'h04;
  localparam logic [ADDR_W-1:0] REG_CMD = 8'h08;
  localparam logic [ADDR_W-1:0] REG_COUNT = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_DATA = 8'h10;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h14;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_DEC_LSB = 2;
  localparam int CTRL_PHASE_LSB = 4;
  localparam int CTRL_SRC_POL = 6;
  localparam int CTRL_START_POL = 7;
  localparam int CTRL_STOP_POL = 8;
  localparam int CTRL_RELOAD_EN = 9;
  localparam int CTRL_SAMPLE_EN = 10;
  localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;
  localparam int CMD_ARM = 0;
  localparam int CMD_DISARM = 1;
  localparam int STAT_ARMED = 0;
  localparam int STAT_COUNTING = 1;
  localparam int STAT_DATA_VALID = 2;
  localparam int STAT_OVERRUN = 3;

  // ****************************************************************
  // modes, decoders, states
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_PERIOD = 2'b00,
    MODE_POSITION = 2'b01,
    MODE_EDGE_SEP = 2'b10
  } cppm_mode_t;

  typedef enum logic [1:0] {
    DEC_SINGLE_EDGE_DECODE = 2'b00,
    DEC_DOUBLE_EDGE_DECODE = 2'b01,
    DEC_QUAD_EDGE_DECODE = 2'b10,
    DEC_TWO_PULSE = 2'b11
  } cppm_dec_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_COUNT = 2'b10,
    ST_RUN = 2'b11
  } cppm_state_t;

endpackage

// ---- src/cppm_stream_if.sv ----
// valid/ready word stream between the block's own modules
`timescale 1ns/1ps
`default_nettype none
interface cppm_stream_if;
  import cppm_pkg::*;
  logic valid;
  logic ready;
  logic [CNT_W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ---- src/cppm_sync.sv ----
// two-flop input synchroniser with rise and fall detection
`timescale 1ns/1ps
`default_nettype none
module cppm_sync (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic pin_in,
  output logic level,
  output logic rise,
  output logic fall
);
  import cppm_pkg::*;

  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // first stage feeds only the second; edges come from stages two and three
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // one pulse per edge, so no edge is counted twice
  assign level = sync_reg;
  assign rise = sync_reg & ~last_reg;
  assign fall = ~sync_reg & last_reg;
endmodule // cppm_sync
`default_nettype wire

// ---- src/cppm_top.sv ----
// counter block: period, quadrature / two-pulse position, edge separation
//
// Functional notes
// - period bounded by two like stop edges
// - count source edges between bounding stop edges
// - position and separation wait for arming
// - single edge: up on A rise, down fall
// - double edge: count both A edges
// - quad edge: count every A, B edge
// - index high in chosen phase reloads counter; code skips the reload in two-pulse decode
// - count change first, reload afterwards
// - reload within one timebase cycle, then resume
// - two-pulse: A rise up, B rise down
// - buffered position latches on each sample edge
// - latched values cumulative, sample never clears
// - sample clock on stop input, chosen edge
// - separation: start edge begins, stop edge ends
// - start edges ignored while counting
// - stop edge halts, count goes to queue
// - start and stop polarities set independently
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module cppm_top (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cppm_pkg::ADDR_W-1:0] paddr,
  input wire logic [cppm_pkg::CNT_W-1:0] pwdata,
  output logic [cppm_pkg::CNT_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic src_in,
  input wire logic start_in,
  input wire logic stop_in,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_z
);
  import cppm_pkg::*;

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  logic src_lvl;
  logic src_rise;
  logic src_fall;
  logic start_lvl;
  logic start_rise;
  logic start_fall;
  logic stop_lvl;
  logic stop_rise;
  logic stop_fall;
  logic a_lvl;
  logic a_rise;
  logic a_fall;
  logic b_lvl;
  logic b_rise;
  logic b_fall;
  logic z_lvl;

  cppm_sync u_sync_src (
    .mclk(mclk), .sys_rst(sys_rst), .pin_in(src_in),
    .level(src_lvl), .rise(src_rise), .fall(src_fall)
  );
  cppm_sync u_sync_start (
    .mclk(mclk), .sys_rst(sys_rst), .pin_in(start_in),
    .level(start_lvl), .rise(start_rise), .fall(start_fall)
  );
  cppm_sync u_sync_stop (
    .mclk(mclk), .sys_rst(sys_rst), .pin_in(stop_in),
    .level(stop_lvl), .rise(stop_rise), .fall(stop_fall)
  );
  cppm_sync u_sync_a (
    .mclk(mclk), .sys_rst(sys_rst), .pin_in(enc_a),
    .level(a_lvl), .rise(a_rise), .fall(a_fall)
  );
  cppm_sync u_sync_b (
    .mclk(mclk), .sys_rst(sys_rst), .pin_in(enc_b),
    .level(b_lvl), .rise(b_rise), .fall(b_fall)
  );
  cppm_sync u_sync_z (
    .mclk(mclk), .sys_rst(sys_rst), .pin_in(enc_z),
    .level(z_lvl), .rise(), .fall()
  );

  // ****************************************************************
  // configuration fields
  // ****************************************************************
  logic [CTRL_W-1:0] ctrl_reg;
  logic [CTRL_W-1:0] ctrl_next;
  logic [CNT_W-1:0] reload_reg;
  logic [CNT_W-1:0] reload_next;
  cppm_mode_t mode;
  cppm_dec_t dec;
  logic [1:0] phase_sel;
  logic src_edge;
  logic start_edge;
  logic stop_edge;

  // software settings steer the decode, reload and measurement decisions below
  assign mode = cppm_mode_t'(ctrl_reg[CTRL_MODE_LSB +: 2]);
  assign dec = cppm_dec_t'(ctrl_reg[CTRL_DEC_LSB +: 2]);
  assign phase_sel = ctrl_reg[CTRL_PHASE_LSB +: 2];

  // active edge selection; each input has its own polarity bit
  assign src_edge = ctrl_reg[CTRL_SRC_POL] ? src_fall : src_rise;
  assign start_edge = ctrl_reg[CTRL_START_POL] ? start_fall : start_rise;
  assign stop_edge = ctrl_reg[CTRL_STOP_POL] ? stop_fall : stop_rise;

  // ****************************************************************
  // position decoder
  // ****************************************************************
  logic b_prev_reg;
  logic a_chg;
  logic b_chg;
  logic q_dir_up;
  logic step_up;
  logic step_dn;
  logic reload_hit;
  logic [CNT_W-1:0] pos_next;
  logic [CNT_W-1:0] cnt_reg;

  // b from the previous cycle gives the direction of a single change
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      b_prev_reg <= 1'b0;
    end else begin
      b_prev_reg <= b_lvl;
    end
  end

  assign a_chg = a_rise | a_fall;
  assign b_chg = b_rise | b_fall;
  // a leading b walks 00,10,11,01: a xor old b is one on each step
  assign q_dir_up = a_lvl ^ b_prev_reg;

  // step decision per decoding mode
  always_comb begin
    step_up = 1'b0;
    step_dn = 1'b0;
    case (dec)
      DEC_SINGLE_EDGE_DECODE: begin
        // one count per cycle, only on a edges while b is low
        step_up = a_rise & ~b_lvl;
        step_dn = a_fall & ~b_lvl;
      end
      DEC_DOUBLE_EDGE_DECODE: begin
        // both a edges, direction from the leading channel
        step_up = a_chg & q_dir_up;
        step_dn = a_chg & ~q_dir_up;
      end
      DEC_QUAD_EDGE_DECODE: begin
        // every edge of a or b; a double change is invalid, dropped
        step_up = (a_chg ^ b_chg) & q_dir_up;
        step_dn = (a_chg ^ b_chg) & ~q_dir_up;
      end
      DEC_TWO_PULSE: begin
        // coincident pulses cancel out
        step_up = a_rise & ~b_rise;
        step_dn = b_rise & ~a_rise;
      end
      default: begin
        step_up = 1'b0;
        step_dn = 1'b0;
      end
    endcase
  end

  // index high while the channels sit in the chosen phase
  assign reload_hit = ctrl_reg[CTRL_RELOAD_EN] & (dec != DEC_TWO_PULSE)
                      & z_lvl & ({a_lvl, b_lvl} == phase_sel);

  // count change first, the reload then overrides it in the same cycle,
  // so the reload lands one timebase cycle after the phase turns true
  always_comb begin
    pos_next = cnt_reg;
    if (step_up) begin
      pos_next = cnt_reg + CNT_ONE;
    end else if (step_dn) begin
      pos_next = cnt_reg - CNT_ONE;
    end
    if (reload_hit) begin
      pos_next = reload_reg;
    end
  end

  // ****************************************************************
  // measurement state machine
  // ****************************************************************
  cppm_state_t st_reg;
  cppm_state_t st_next;
  logic [CNT_W-1:0] cnt_next;
  logic cap_evt;
  logic [CNT_W-1:0] cap_val;
  logic cmd_arm;
  logic cmd_disarm;

  // sequencing of all three measurement kinds
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    cap_evt = 1'b0;
    cap_val = cnt_reg;
    if (cmd_disarm) begin
      st_next = ST_IDLE;
    end else begin
      case (st_reg)
        ST_IDLE: begin
          // nothing counts before the arm command
          if (cmd_arm) begin
            cnt_next = CNT_ZERO;
            st_next = (mode == MODE_POSITION) ? ST_RUN : ST_WAIT;
          end
        end
        ST_WAIT: begin
          // period opens on a stop edge, separation on a start edge
          if (mode == MODE_PERIOD && stop_edge) begin
            cnt_next = CNT_ZERO;
            st_next = ST_COUNT;
          end else if (mode == MODE_EDGE_SEP && start_edge) begin
            cnt_next = CNT_ZERO;
            st_next = ST_COUNT;
          end
        end
        ST_COUNT: begin
          // start edges have no branch here, so they are ignored
          if (stop_edge) begin
            // a source edge in the closing cycle is left out
            cap_evt = 1'b1;
            cap_val = cnt_reg;
            st_next = ST_IDLE;
          end else if (src_edge) begin
            cnt_next = cnt_reg + CNT_ONE;
          end
        end
        ST_RUN: begin
          cnt_next = pos_next;
          // latch the running total; the counter itself is untouched
          if (ctrl_reg[CTRL_SAMPLE_EN] && stop_edge) begin
            cap_evt = 1'b1;
            cap_val = cnt_reg;
          end
        end
        default: begin
          st_next = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_reg <= ST_IDLE;
      cnt_reg <= CNT_ZERO;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
    end
  end

  // ****************************************************************
  // result queue
  // ****************************************************************
  cppm_stream_if fill_if ();
  cppm_stream_if drain_if ();
  logic pend_reg;
  logic pend_next;
  logic [CNT_W-1:0] pend_data_reg;
  logic [CNT_W-1:0] pend_data_next;
  logic ovr_reg;
  logic ovr_next;
  logic ovr_clr;

  // one holding stage ahead of the buffer; it waits out a full buffer
  assign fill_if.valid = pend_reg;
  assign fill_if.data = pend_data_reg;

  // a new word while the old one is still stuck is dropped and flagged
  always_comb begin
    pend_next = pend_reg & ~fill_if.ready;
    pend_data_next = pend_data_reg;
    ovr_next = ovr_reg & ~ovr_clr;
    if (cap_evt) begin
      if (pend_reg && !fill_if.ready) begin
        ovr_next = 1'b1; // set wins over a clear in the same cycle
      end else begin
        pend_next = 1'b1;
        pend_data_next = cap_val;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pend_reg <= 1'b0;
      pend_data_reg <= CNT_ZERO;
      ovr_reg <= 1'b0;
    end else begin
      pend_reg <= pend_next;
      pend_data_reg <= pend_data_next;
      ovr_reg <= ovr_next;
    end
  end

  cppm_buf2 u_buf (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .fill(fill_if.snk),
    .drain(drain_if.src)
  );

  // ****************************************************************
  // apb slave
  // ****************************************************************
  logic setup;
  logic access;
  logic wr_acc;
  logic mapped;
  logic [CNT_W-1:0] rd_mux;
  logic [CNT_W-1:0] prdata_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic [CNT_W-1:0] status;

  // zero wait states: read data is fetched in the setup cycle
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wr_acc = access & pwrite;
  assign pready = access;
  assign pslverr = pslverr_reg;

  assign mapped = (paddr == REG_CTRL) | (paddr == REG_RELOAD) |
                  (paddr == REG_CMD) | (paddr == REG_COUNT) |
                  (paddr == REG_DATA) | (paddr == REG_STATUS);

  // command and clear strobes act only at the access edge
  assign cmd_arm = wr_acc & (paddr == REG_CMD) & pwdata[CMD_ARM];
  assign cmd_disarm = wr_acc & (paddr == REG_CMD) & pwdata[CMD_DISARM];
  assign ovr_clr = wr_acc & (paddr == REG_STATUS) & pwdata[STAT_OVERRUN];
  // reading the data word pops it from the buffer
  assign drain_if.ready = access & ~pwrite & (paddr == REG_DATA);

  always_comb begin
    status = CNT_ZERO;
    status[STAT_ARMED] = (st_reg != ST_IDLE);
    status[STAT_COUNTING] = (st_reg == ST_COUNT) | (st_reg == ST_RUN);
    status[STAT_DATA_VALID] = drain_if.valid;
    status[STAT_OVERRUN] = ovr_reg;
  end

  // read multiplexer; the live count serves on-demand position reads
  always_comb begin
    rd_mux = CNT_ZERO;
    case (paddr)
      REG_CTRL: rd_mux = {{(CNT_W-CTRL_W){1'b0}}, ctrl_reg};
      REG_RELOAD: rd_mux = reload_reg;
      REG_COUNT: rd_mux = cnt_reg;
      REG_DATA: rd_mux = drain_if.valid ? drain_if.data : CNT_ZERO;
      REG_STATUS: rd_mux = status;
      default: rd_mux = CNT_ZERO;
    endcase
  end

  // register writes and captured answer
  always_comb begin
    ctrl_next = ctrl_reg;
    reload_next = reload_reg;
    prdata_next = prdata;
    pslverr_next = pslverr_reg;
    if (setup) begin
      prdata_next = pwrite ? CNT_ZERO : rd_mux;
      pslverr_next = ~mapped;
    end
    if (wr_acc && paddr == REG_CTRL) begin
      ctrl_next = pwdata[CTRL_W-1:0];
    end
    if (wr_acc && paddr == REG_RELOAD) begin
      reload_next = pwdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_reg <= CTRL_RST;
      reload_reg <= CNT_ZERO;
      prdata <= CNT_ZERO;
      pslverr_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      reload_reg <= reload_next;
      prdata <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // unused synchronised levels kept for visibility in waveforms
  logic unused_lvls;
  assign unused_lvls = src_lvl ^ start_lvl ^ stop_lvl;

endmodule // cppm_top
`default_nettype wire
